//--- hw/tdm_rate_pkg.sv
package tdm_rate_pkg;
  // Register offsets on the plain register port.
  localparam logic [7:0] OFFS_LOCAL_RATE   = 8'h00;
  localparam logic [7:0] OFFS_REDUCED_RATE = 8'h04;
  localparam logic [7:0] OFFS_STROBE_CTRL  = 8'h08;
  localparam logic [7:0] OFFS_SYNC_OFFSET  = 8'h0C;
  localparam logic [7:0] OFFS_TX_PINS      = 8'h10;
  localparam logic [7:0] OFFS_STATUS       = 8'h14;
  // Field positions.
  localparam int RATE_LSB     = 0;
  localparam int HALVE_BIT    = 4;
  localparam int SHARE_BIT    = 5;
  localparam int DIV_LSB      = 0;
  localparam int BUSRED_BIT   = 7;
  localparam int STRB_EN_BIT  = 0;
  localparam int STRB_DIR_BIT = 1;
  localparam int STAT_IDX_LSB = 8;
  localparam int STAT_SHR_BIT = 12;
  localparam int STAT_STB_BIT = 13;
  localparam int STAT_PER_LSB = 16;
  // Codes of the local rate field.
  localparam logic [2:0] RATE_X1   = 3'h0;
  localparam logic [2:0] RATE_DIV2 = 3'h1;
  localparam logic [2:0] RATE_DIV4 = 3'h2;
  localparam logic [2:0] RATE_DIVN = 3'h3;
  localparam logic [2:0] RATE_X2   = 3'h4;
  localparam logic [2:0] RATE_X4   = 3'h5;
  // Divisor limits and values after reset.
  localparam logic [5:0] DIV_MIN       = 6'h02;
  localparam logic [5:0] DIV_MAX       = 6'h20;
  localparam logic [5:0] DIV_RESET     = 6'h02;
  localparam logic [7:0] LOCAL_RESET   = 8'h00;
  localparam logic [1:0] STROBE_RESET  = 2'h0;
  localparam logic [4:0] OFFSET_RESET  = 5'h00;
  localparam logic [2:0] TRANSMIT_PIN_COUNT_RESET  = 3'h0;
endpackage

//--- hw/edge_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; the level changes once stages two and three agree.
module edge_sync (
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // Asynchronous input.
  input  wire logic async_in,
  // Filtered level and its edges.
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic [2:0] sync_ff;
  logic       lvl_ff;
  logic       agree;
  logic       nxt_lvl;

  // The first stage feeds only the second.
  assign agree   = sync_ff[1] == sync_ff[2];
  assign nxt_lvl = agree ? sync_ff[2] : lvl_ff;

  // Shift chain and held level.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_ff <= 3'h0;
      lvl_ff  <= 1'b0;
    end else begin
      sync_ff <= {sync_ff[1:0], async_in};
      lvl_ff  <= nxt_lvl;
    end
  end

  assign level_out = lvl_ff;
  assign rise_out  = nxt_lvl & ~lvl_ff;
  assign fall_out  = ~nxt_lvl & lvl_ff;
endmodule

//--- hw/frame_divider.sv
`timescale 1ns/1ps
// Modulo counter of superframes, advanced by a step and reloadable to zero.
module frame_divider #(
  parameter int W = 6
) (
  // Clock and reset.
  input  wire logic         clk_in,
  input  wire logic         arst_n_in,
  // Control.
  input  wire logic         step_in,
  input  wire logic         clear_in,
  input  wire logic [W-1:0] modulus_in,
  // Count.
  output logic [W-1:0]      count_out
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] inc;
  logic [W-1:0] nxt_cnt;

  // Wraps at the modulus; a modulus of zero or one holds the count at zero.
  assign inc     = cnt_ff + W'(1);
  assign nxt_cnt = (clear_in || inc >= modulus_in) ? '0 : inc;

  // Count only on a superframe step.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_ff <= '0;
    end else if (step_in) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign count_out = cnt_ff;
endmodule

//--- hw/tdm_rate_adapter.sv
// Behaviour
// - Local TDM frame rate is one, two or four times the superframe rate.
// - Double rate with halving uses only receive channels zero and one upstream.
// - Double rate with halving repeats the two downstream slots across transmit channels.
// - Increased rate maps buffer entries to channels in plain sequence, no conversion.
// - Rate field divides superframe rate by two, four or the programmed divisor.
// - With bus reduction, bus slots are placed once every divisor superframes.
// - Slot sharing acts only in reduced-rate nodes with transmit disabled.
// - Enabled strobe marks the full-rate frame carrying new reduced-rate data.
// - Strobe direction bit makes the strobe pin an output or input.
// - Each node keeps its own reduced-rate counter; output strobe comes from it.
// - Input strobe is sampled on the active sync edge and resets the counter.
// - Local sync edge is shifted by a programmed whole number of superframes.
// - Division ratios run from two up to thirty-two.
// - Sharing multiplexes two-to-one at half rate, four-to-one lower, within one node.
// - Reduced-rate receive data may be forwarded upstream or downstream.
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module tdm_rate_adapter #(
  parameter int PER_W = 16
) (
  // Clock and reset.
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // Register port.
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  // Link timing from outside the clock domain.
  input  wire logic        bclk_in,
  input  wire logic        sframe_sync_in,
  // Local TDM port.
  input  wire logic [5:0]  tdm_slots_in,
  input  wire logic [4:0]  chan_in,
  output logic             tdm_sync_out,
  output logic             rx_use_out,
  output logic [6:0]       rx_index_out,
  output logic [6:0]       tx_index_out,
  // Bus slot control.
  output logic             bus_slot_en_out,
  output logic             share_active_out,
  output logic [1:0]       share_phase_out,
  // Strobe pin.
  input  wire logic        strobe_in,
  output logic             strobe_out,
  output logic             strobe_oe_out
);
  // Configuration registers.
  logic [7:0]       local_rate_register_ff;
  logic [5:0]       reduced_rate_divisor_ff;
  logic             bus_reduction_bit_ff;
  logic [1:0]       strobe_control_register_ff;
  logic [4:0]       sync_offset_field_ff;
  logic [2:0]       transmit_pin_count_ff;
  logic [31:0]      rdata_ff;
  // Timing state.
  logic [PER_W-1:0] bclk_cnt_ff;
  logic [PER_W-1:0] period_ff;
  logic [1:0]       frame_idx_ff;
  logic             tdm_sync_ff;
  logic             strobe_ff;
  logic             bus_slot_ff;
  logic             rx_use_ff;
  logic [6:0]       rx_index_ff;
  logic [6:0]       tx_index_ff;
  // Synchronised link signals.
  logic             bclk_rise;
  logic             sf_rise;
  logic             strobe_lvl;

  // Divide ratio and rate decode.
  logic [2:0]       local_rate_field;
  logic [5:0]       div_eff;
  logic [5:0]       wr_div;
  logic             reduced;
  logic             halve;
  logic             share_active;
  logic             strobe_is_out;
  logic [5:0]       rr_cnt;
  logic [5:0]       nxt_rr_cnt;
  logic             rr_clear;
  logic             update_frame;
  logic [1:0]       phase;
  logic [1:0]       share_mask;
  logic             quarter_hit;
  logic [PER_W-1:0] q1;
  logic [PER_W-1:0] q2;
  logic [PER_W-1:0] q3;
  logic             strobe_enabled;
  logic             bus_reduced;
  logic             slot_in_frame;
  logic [31:0]      status_word;

  // Buffer entry of a channel in a given local frame, laid out in sequence.
  function automatic logic [6:0] entry_index(input logic [1:0] frame,
                                             input logic [5:0] per_frame,
                                             input logic [4:0] chan);
    logic [8:0] prod;
    prod = 9'(frame) * 9'(per_frame) + 9'(chan);
    return prod[6:0];
  endfunction

  // Clamp a written divisor into the supported ratio range.
  // Only the divisor field is looked at: the bus reduction bit shares the written word.
  function automatic logic [5:0] clamp_div(input logic [31:0] val);
    logic [5:0] res;
    res = val[tdm_rate_pkg::DIV_LSB +: 6];
    if (res > tdm_rate_pkg::DIV_MAX) begin
      res = tdm_rate_pkg::DIV_MAX;
    end else if (val[5:0] < tdm_rate_pkg::DIV_MIN) begin
      res = tdm_rate_pkg::DIV_MIN;
    end
    return res;
  endfunction

  // Link clock and superframe sync each pass three flip-flops.
  edge_sync u_bclk_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  (bclk_in),
    .level_out (),
    .rise_out  (bclk_rise),
    .fall_out  ()
  );

  edge_sync u_sf_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  (sframe_sync_in),
    .level_out (),
    .rise_out  (sf_rise),
    .fall_out  ()
  );

  edge_sync u_strobe_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .async_in  (strobe_in),
    .level_out (strobe_lvl),
    .rise_out  (),
    .fall_out  ()
  );

  // Rate field decode into a superframe divide ratio.
  assign local_rate_field = local_rate_register_ff[tdm_rate_pkg::RATE_LSB +: 3];
  assign div_eff = (local_rate_field == tdm_rate_pkg::RATE_DIV2) ? 6'h02 :
                   (local_rate_field == tdm_rate_pkg::RATE_DIV4) ? 6'h04 :
                   (local_rate_field == tdm_rate_pkg::RATE_DIVN) ? reduced_rate_divisor_ff :
                   6'h01;
  assign reduced = div_eff > 6'h01;
  assign halve   = local_rate_register_ff[tdm_rate_pkg::HALVE_BIT] &&
                   local_rate_field == tdm_rate_pkg::RATE_X2;
  assign wr_div  = clamp_div(reg_wdata_in);

  // Sharing needs a reduced rate and no transmit pins.
  assign share_active = local_rate_register_ff[tdm_rate_pkg::SHARE_BIT] && reduced &&
                        transmit_pin_count_ff == 3'h0;
  assign share_mask   = (div_eff == 6'h02) ? 2'h1 : 2'h3;
  assign phase        = rr_cnt[1:0] & share_mask;

  // Bus reduction only thins out the bus slots of a node that runs at a reduced rate.
  // Software keeps it off while sharing, since a skipped slot would lose a shared word.
  assign bus_reduced  = bus_reduction_bit_ff && reduced;

  // Strobe direction and the input strobe seen at the superframe edge.
  // The input is taken as a level, since it stands across the superframe edge.
  assign strobe_enabled = strobe_control_register_ff[tdm_rate_pkg::STRB_EN_BIT];
  assign strobe_is_out  = strobe_control_register_ff[tdm_rate_pkg::STRB_DIR_BIT];
  assign rr_clear       = strobe_enabled && !strobe_is_out && strobe_lvl;

  // Reduced-rate superframe counter kept locally.
  frame_divider #(
    .W (6)
  ) u_rr_div (
    .clk_in     (clk_in),
    .arst_n_in  (arst_n_in),
    .step_in    (sf_rise),
    .clear_in   (rr_clear),
    .modulus_in (div_eff),
    .count_out  (rr_cnt)
  );

  // Counter value that the coming superframe will carry.
  // At a reduced rate an offset at or above the divide ratio never matches, so no local frame starts.
  assign nxt_rr_cnt   = (rr_clear || 6'(rr_cnt + 6'h01) >= div_eff) ? 6'h00 :
                        6'(rr_cnt + 6'h01);
  assign update_frame = !reduced || nxt_rr_cnt == 6'(sync_offset_field_ff);

  // Sub-frame points for increased rates, measured in bit clocks.
  // Until a full superframe has been measured the extra frame starts are missing.
  assign q2 = period_ff >> 1;
  assign q1 = period_ff >> 2;
  assign q3 = PER_W'(q1 + q2);
  assign quarter_hit = bclk_rise && (
                       (local_rate_field == tdm_rate_pkg::RATE_X2 && bclk_cnt_ff == q2) ||
                       (local_rate_field == tdm_rate_pkg::RATE_X4 &&
                        (bclk_cnt_ff == q1 || bclk_cnt_ff == q2 || bclk_cnt_ff == q3)));

  // Register writes; the divisor write is clamped.
  // A write to an unmapped address is dropped without effect.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      local_rate_register_ff     <= tdm_rate_pkg::LOCAL_RESET;
      reduced_rate_divisor_ff    <= tdm_rate_pkg::DIV_RESET;
      bus_reduction_bit_ff       <= 1'b0;
      strobe_control_register_ff <= tdm_rate_pkg::STROBE_RESET;
      sync_offset_field_ff       <= tdm_rate_pkg::OFFSET_RESET;
      transmit_pin_count_ff      <= tdm_rate_pkg::TRANSMIT_PIN_COUNT_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        tdm_rate_pkg::OFFS_LOCAL_RATE: begin
          local_rate_register_ff <= reg_wdata_in[7:0];
        end
        tdm_rate_pkg::OFFS_REDUCED_RATE: begin
          reduced_rate_divisor_ff <= wr_div;
          bus_reduction_bit_ff    <= reg_wdata_in[tdm_rate_pkg::BUSRED_BIT];
        end
        tdm_rate_pkg::OFFS_STROBE_CTRL: begin
          strobe_control_register_ff <= reg_wdata_in[1:0];
        end
        tdm_rate_pkg::OFFS_SYNC_OFFSET: begin
          sync_offset_field_ff <= reg_wdata_in[4:0];
        end
        tdm_rate_pkg::OFFS_TX_PINS: begin
          transmit_pin_count_ff <= reg_wdata_in[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Status word: period, strobe, sharing, local frame index and reduced count.
  assign status_word = {period_ff, 2'h0, strobe_ff, share_active, 2'h0, frame_idx_ff,
                        2'h0, rr_cnt};

  // Register reads answer one cycle later; unmapped addresses read zero.
  // Read data falls back to zero after its one cycle, so nothing stale is seen later.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_ff <= 32'h0;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        tdm_rate_pkg::OFFS_LOCAL_RATE:   rdata_ff <= {24'h0, local_rate_register_ff};
        tdm_rate_pkg::OFFS_REDUCED_RATE: rdata_ff <= {24'h0, bus_reduction_bit_ff, 1'b0,
                                                      reduced_rate_divisor_ff};
        tdm_rate_pkg::OFFS_STROBE_CTRL:  rdata_ff <= {30'h0, strobe_control_register_ff};
        tdm_rate_pkg::OFFS_SYNC_OFFSET:  rdata_ff <= {27'h0, sync_offset_field_ff};
        tdm_rate_pkg::OFFS_TX_PINS:      rdata_ff <= {29'h0, transmit_pin_count_ff};
        tdm_rate_pkg::OFFS_STATUS:       rdata_ff <= status_word;
        default: rdata_ff <= 32'h0;
      endcase
    end else begin
      rdata_ff <= 32'h0;
    end
  end

  // Bit clocks per superframe, latched at each superframe edge.
  // A stopped link clock leaves the period at zero, and increased rates then add no frames.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bclk_cnt_ff <= '0;
      period_ff   <= '0;
    end else if (sf_rise) begin
      // The superframe edge comes with a bit clock edge, which is the first bit counted.
      bclk_cnt_ff <= bclk_rise ? PER_W'(1) : PER_W'(0);
      period_ff   <= bclk_cnt_ff;
    end else if (bclk_rise) begin
      bclk_cnt_ff <= PER_W'(bclk_cnt_ff + PER_W'(1));
    end
  end

  // Local sync: extra frames at increased rate, shifted frames at reduced rate.
  // At a reduced rate only the superframe whose new count equals the offset starts a frame.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tdm_sync_ff  <= 1'b0;
      frame_idx_ff <= 2'h0;
    end else if (sf_rise) begin
      tdm_sync_ff  <= update_frame;
      frame_idx_ff <= 2'h0;
    end else if (quarter_hit) begin
      tdm_sync_ff  <= 1'b1;
      frame_idx_ff <= 2'(frame_idx_ff + 2'h1);
    end else begin
      tdm_sync_ff  <= 1'b0;
    end
  end

  // Strobe output held for the whole superframe of new data; bus slot gating.
  // The strobe register runs in both directions; only the output enable lets it out.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      strobe_ff   <= 1'b0;
      bus_slot_ff <= 1'b1;
    end else if (sf_rise) begin
      strobe_ff   <= strobe_enabled && reduced && update_frame;
      bus_slot_ff <= !bus_reduced || nxt_rr_cnt == 6'h00;
    end
  end

  // A channel is in use while it lies inside the frame; all 32 slots must fit.
  assign slot_in_frame = {1'b0, chan_in} < tdm_slots_in;

  // Channel mapping into frame buffer entries.
  // Halving wins over sharing; they never meet, as one is increased and one reduced.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_use_ff   <= 1'b0;
      rx_index_ff <= 7'h00;
      tx_index_ff <= 7'h00;
    end else if (halve) begin
      rx_use_ff   <= chan_in < 5'h02;
      rx_index_ff <= entry_index(frame_idx_ff, 6'h02, chan_in);
      tx_index_ff <= {6'h00, chan_in[0]};
    end else if (share_active) begin
      rx_use_ff   <= (chan_in[1:0] & share_mask) == phase;
      rx_index_ff <= (share_mask == 2'h1) ? {3'h0, chan_in[4:1]} : {4'h0, chan_in[4:2]};
      tx_index_ff <= 7'h00;
    end else begin
      rx_use_ff   <= slot_in_frame;
      rx_index_ff <= entry_index(frame_idx_ff, tdm_slots_in, chan_in);
      tx_index_ff <= entry_index(frame_idx_ff, tdm_slots_in, chan_in);
    end
  end

  // Outputs.
  assign reg_rdata_out    = rdata_ff;
  assign tdm_sync_out     = tdm_sync_ff;
  assign rx_use_out       = rx_use_ff;
  assign rx_index_out     = rx_index_ff;
  assign tx_index_out     = tx_index_ff;
  assign bus_slot_en_out  = bus_slot_ff;
  assign share_active_out = share_active;
  assign share_phase_out  = phase;
  assign strobe_out       = strobe_ff;
  assign strobe_oe_out    = strobe_enabled && strobe_is_out;
endmodule

//--- verif/tdm_rate_checker.sv
`timescale 1ns/1ps
// Watches the register port, the superframe sync and the local frame outputs.
module tdm_rate_checker (
  // Clock and reset.
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  // Register port.
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Link and frame timing.
  input wire logic        sframe_sync_in,
  input wire logic        tdm_sync_out,
  input wire logic        bus_slot_en_out,
  input wire logic        strobe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  // Read data stands only in the cycle after a read strobe.
  a_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data not zero outside a read answer");
  a_unmapped_read: assert property ($past(reg_rd_in) && $past(reg_addr_in) > 8'h14
    |-> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
  a_transmit_pin_count_field: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == tdm_rate_pkg::OFFS_TX_PINS
    |-> reg_rdata_out[31:3] == 29'h0) else $error("pin count upper bits set");
  a_div_range: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) == tdm_rate_pkg::OFFS_REDUCED_RATE
    |-> reg_rdata_out[5:0] >= tdm_rate_pkg::DIV_MIN && reg_rdata_out[5:0] <= tdm_rate_pkg::DIV_MAX)
    else $error("divisor outside two to thirty-two");
  // Frame and strobe timing.
  a_sync_spacing: assert property ($rose(tdm_sync_out) |=> !tdm_sync_out [*8])
    else $error("local sync not a spaced single pulse");
  a_strobe_held: assert property ($rose(strobe_out) |=> strobe_out [*8])
    else $error("strobe dropped inside its frame");
  a_strobe_sync: assert property ($rose(strobe_out) |-> tdm_sync_out)
    else $error("strobe rose without a local frame start");
  a_slot_edge: assert property ($changed(bus_slot_en_out) |-> $past(sframe_sync_in, 4))
    else $error("bus slot enable changed away from a superframe edge");
endmodule

bind tdm_rate_adapter tdm_rate_checker i_tdm_rate_checker (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sframe_sync_in(sframe_sync_in),
  .tdm_sync_out(tdm_sync_out), .bus_slot_en_out(bus_slot_en_out), .strobe_out(strobe_out)
);

//--- verif/tdm_link_model.sv
`timescale 1ns/1ps
// Far side of the link: bit clock, superframe sync and an optional strobe source.
module tdm_link_model #(
  parameter int SF_BITS = 16
) (
  // Strobe source control.
  input  wire logic       strb_drive_in,
  input  wire logic [5:0] strb_div_in,
  // Link pins.
  output logic            bclk_out,
  output logic            sync_out,
  output logic            strobe_out
);
  int bit_cnt = 0;
  int sf_cnt  = 0;

  // The bus bit clock runs free; its phase is offset from the system clock.
  initial begin
    bclk_out = 1'b0;
    #37;
    forever #100 bclk_out = ~bclk_out;
  end

  // The strobe period counter steps one bit before each superframe edge.
  always @(posedge bclk_out) begin
    bit_cnt <= (bit_cnt == SF_BITS - 1) ? 0 : bit_cnt + 1;
    if (bit_cnt == SF_BITS - 2) begin
      sf_cnt <= (sf_cnt + 1 >= int'(strb_div_in)) ? 0 : sf_cnt + 1;
    end
  end

  // Sync marks the first bit; the strobe spans the edge that starts each period.
  assign sync_out   = (bit_cnt == 0);
  assign strobe_out = strb_drive_in && (sf_cnt == 0);
endmodule

//--- verif/tdm_rate_adapter_tb.sv
`timescale 1ns/1ps
module tdm_rate_adapter_tb;
  localparam int SF_CLK = 128; // System clocks in one superframe of 16 bit clocks.
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [5:0]  tdm_slots_in = 6'h08;
  logic [4:0]  chan_in = 5'h00;
  logic        strb_drive = 1'b0;
  logic [31:0] reg_rdata_out;
  logic        bclk_in, sframe_sync_in, strobe_in, tdm_sync_out, rx_use_out;
  logic [6:0]  rx_index_out, tx_index_out;
  logic        bus_slot_en_out, share_active_out, strobe_out, strobe_oe_out;
  logic [1:0]  share_phase_out;
  int          err_count = 0;
  int          check_count = 0;

  // System clock of 40 MHz.
  always #12.5 clk_in = ~clk_in;

  tdm_rate_adapter i_tdm_rate_adapter (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .bclk_in(bclk_in), .sframe_sync_in(sframe_sync_in),
    .tdm_slots_in(tdm_slots_in), .chan_in(chan_in), .tdm_sync_out(tdm_sync_out),
    .rx_use_out(rx_use_out), .rx_index_out(rx_index_out), .tx_index_out(tx_index_out),
    .bus_slot_en_out(bus_slot_en_out), .share_active_out(share_active_out),
    .share_phase_out(share_phase_out), .strobe_in(strobe_in), .strobe_out(strobe_out),
    .strobe_oe_out(strobe_oe_out)
  );
  tdm_link_model i_tdm_link_model (
    .strb_drive_in(strb_drive), .strb_div_in(6'h04), .bclk_out(bclk_in),
    .sync_out(sframe_sync_in), .strobe_out(strobe_in)
  );

  // Comparison, register access and measurement helpers.
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    #1 check(name, exp, reg_rdata_out);
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Counts local frame starts over eight superframes; samples slots and strobe mid-frame.
  task automatic measure(output int s, output int b, output int t);
    s = 0;
    b = 0;
    t = 0;
    @(posedge sframe_sync_in);
    repeat (8) begin
      for (int c = 0; c < SF_CLK; c++) begin
        wait_clk(1);
        s += int'(tdm_sync_out === 1'b1);
        if (c == SF_CLK / 2) begin
          b += int'(bus_slot_en_out === 1'b1);
          t += int'(strobe_out === 1'b1);
        end
      end
    end
  endtask
  task automatic do_reset();
    arst_n_in <= 1'b0;
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run of about 300 us.
  initial begin
    #1000000;
    err_count++;
    stop_test();
  end

  // Main sequence.
  initial begin
    logic [2:0] codes [6];
    int         exp_s [6];
    int         s, b, t;
    codes = '{tdm_rate_pkg::RATE_X1, tdm_rate_pkg::RATE_DIV2, tdm_rate_pkg::RATE_DIV4,
              tdm_rate_pkg::RATE_DIVN, tdm_rate_pkg::RATE_X2, tdm_rate_pkg::RATE_X4};
    exp_s = '{8, 4, 2, 1, 16, 32};
    do_reset();
    rd_chk("local reset", tdm_rate_pkg::OFFS_LOCAL_RATE, {24'h0, tdm_rate_pkg::LOCAL_RESET});
    rd_chk("div reset", tdm_rate_pkg::OFFS_REDUCED_RATE, {26'h0, tdm_rate_pkg::DIV_RESET});
    rd_chk("strobe reset", tdm_rate_pkg::OFFS_STROBE_CTRL, {30'h0, tdm_rate_pkg::STROBE_RESET});
    rd_chk("offset reset", tdm_rate_pkg::OFFS_SYNC_OFFSET, {27'h0, tdm_rate_pkg::OFFSET_RESET});
    rd_chk("pins reset", tdm_rate_pkg::OFFS_TX_PINS, {29'h0, tdm_rate_pkg::TRANSMIT_PIN_COUNT_RESET});
    rd_chk("unmapped", 8'h18, 32'h0);
    reg_wr(tdm_rate_pkg::OFFS_REDUCED_RATE, 32'h01);
    rd_chk("div low", tdm_rate_pkg::OFFS_REDUCED_RATE, {26'h0, tdm_rate_pkg::DIV_MIN});
    reg_wr(tdm_rate_pkg::OFFS_REDUCED_RATE, 32'hBF);
    rd_chk("div high", tdm_rate_pkg::OFFS_REDUCED_RATE, {24'h0, 2'h2, tdm_rate_pkg::DIV_MAX});
    $display("test registers done");
    // Every rate code, with divisor eight and full bus rate.
    reg_wr(tdm_rate_pkg::OFFS_REDUCED_RATE, 32'h08);
    for (int i = 0; i < 6; i++) begin
      reg_wr(tdm_rate_pkg::OFFS_LOCAL_RATE, {29'h0, codes[i]});
      wait_clk(2 * SF_CLK);
      measure(s, b, t);
      check("frame starts", exp_s[i], s);
      check("full bus slots", 8, b);
    end
    $display("test rates done");
    // Divide by four, offset one, strobe out, bus reduction.
    reg_wr(tdm_rate_pkg::OFFS_REDUCED_RATE, 32'h84);
    reg_wr(tdm_rate_pkg::OFFS_SYNC_OFFSET, 32'h01);
    reg_wr(tdm_rate_pkg::OFFS_STROBE_CTRL, 32'h03);
    reg_wr(tdm_rate_pkg::OFFS_LOCAL_RATE, {29'h0, tdm_rate_pkg::RATE_DIVN});
    wait_clk(2 * SF_CLK);
    check("strobe drive", 1, strobe_oe_out);
    measure(s, b, t);
    check("reduced starts", 2, s);
    check("strobe frames", 2, t);
    check("reduced slots", 2, b);
    do wait_clk(1); while (tdm_sync_out !== 1'b1);
    // Sixteen bit clocks per superframe, strobe set, reduced count equal to the offset.
    rd_chk("count at start", tdm_rate_pkg::OFFS_STATUS, 32'h0010_2001);
    $display("test reduced done");
    // Strobe as input realigns the reduced count.
    reg_wr(tdm_rate_pkg::OFFS_STROBE_CTRL, 32'h01);
    reg_wr(tdm_rate_pkg::OFFS_SYNC_OFFSET, 32'h00);
    wait_clk(2);
    check("strobe released", 0, strobe_oe_out);
    strb_drive <= 1'b1;
    // A strobe that was already high when the source started is not a full one.
    @(negedge strobe_in);
    @(posedge strobe_in);
    @(posedge sframe_sync_in);
    wait_clk(20);
    // Count forced to zero, which matches offset zero, so the strobe register is set.
    rd_chk("strobe aligned", tdm_rate_pkg::OFFS_STATUS, 32'h0010_2000);
    strb_drive <= 1'b0;
    $display("test strobe input done");
    // Second reset, then channel mapping and sharing.
    do_reset();
    chan_in <= 5'h05;
    wait_clk(3);
    check("sequential index", 5, rx_index_out);
    @(posedge clk_in) tdm_slots_in <= 6'h20;
    chan_in <= 5'h1F;
    wait_clk(3);
    check("last of 32 slots", 1, rx_use_out);
    reg_wr(tdm_rate_pkg::OFFS_LOCAL_RATE, 32'h14);
    chan_in <= 5'h03;
    wait_clk(3);
    check("halved unused", 0, rx_use_out);
    check("tx repeat", 1, tx_index_out);
    @(posedge clk_in) chan_in <= 5'h01;
    wait_clk(3);
    check("halved used", 1, rx_use_out);
    // Divide by two with sharing: bus reduction and offset are still zero from reset.
    reg_wr(tdm_rate_pkg::OFFS_LOCAL_RATE, 32'h21);
    chan_in <= 5'h05;
    wait_clk(3);
    check("share on", 1, share_active_out);
    check("share slot", 2, rx_index_out);
    check("share phase", 0, share_phase_out[1]);
    reg_wr(tdm_rate_pkg::OFFS_TX_PINS, 32'h01);
    wait_clk(2);
    check("share off", 0, share_active_out);
    $display("test mapping done");
    stop_test();
  end
endmodule
